/* File: logic/tka_map.svh */
`ifndef TKA_MAP_SVH
`define TKA_MAP_SVH
// **********************************************************************
// Serial command byte and link addresses
// **********************************************************************
`define TKA_CMD_READ   7
`define TKA_ADR_CTL    7'h0f
`define TKA_ADR_TIME   7'h10
`define TKA_CMD_BITS   6'h08
`define TKA_CTL_BITS   6'h10
`define TKA_TIME_BITS  6'h28
// **********************************************************************
// Control word layout and reset value
// **********************************************************************
`define TKA_CTL_UNLOCK 12
`define TKA_CTL_RUN    11
`define TKA_CTL_RST    16'h0800
// **********************************************************************
// Timekeeping constants
// **********************************************************************
`define TKA_XTAL_HZ    32768
`define TKA_TICK_HZ    256
`define TKA_TICK_LAST  (7'((`TKA_XTAL_HZ / `TKA_TICK_HZ) - 1))
`define TKA_FINE_MAX   8'hff
`define TKA_COARSE_RST 32'h0000_0000
`define TKA_FINE_RST   8'h00
// **********************************************************************
// Host side: serial clock half period and software registers
// **********************************************************************
`define TKA_SCLK_HALF  4'h4
`define TKA_H_TXHI     4'h0
`define TKA_H_TXLO     4'h1
`define TKA_H_CMD      4'h2
`define TKA_H_STAT     4'h3
`define TKA_H_RXHI     4'h4
`define TKA_H_RXLO     4'h5
`define TKA_H_LEN_LSB  8
`define TKA_H_LEN_MSB  13
`endif

/* File: logic/tka_pkg.sv */
package tka_pkg;
  // Device end link phases
  typedef enum logic [2:0] {
    TKA_D_CMD, TKA_D_WCTL, TKA_D_WTIME, TKA_D_RD, TKA_D_SKIP
  } tka_dev_state_type;
  // Host end sequencer states
  typedef enum logic [1:0] {
    TKA_H_IDLE, TKA_H_LOW, TKA_H_HIGH, TKA_H_TAIL
  } tka_host_state_type;
  typedef logic [39:0] tka_word_type;
endpackage

/* File: logic/tka_link_if.sv */
`timescale 1ns/10ps
// **********************************************************************
// Four-wire serial link, all lines sampled on the system clock
// **********************************************************************
interface tka_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev  (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

/* File: logic/tka_device_end.sv */
`timescale 1ns/10ps
`include "tka_map.svh"
module tka_device_end
(
  // Clock, reset, enable
  input  wire logic   CLK,
  input  wire logic   RST,
  input  wire logic   CE,
  // Crystal clock, sampled on CLK
  input  wire logic   XTAL_32K,
  // Serial link
  tka_link_if.dev     link,
  // Counter and control view
  output logic [31:0] COARSE_TIME,
  output logic [7:0]  FINE_TIME,
  output logic        WRITE_UNLOCK,
  output logic        RUN_ENABLE
);
  import tka_pkg::*;

  // **********************************************************************
  // Declarations
  // **********************************************************************
  // Named copy of the control reset word, so single bits can be picked
  localparam logic [15:0] CTL_RST = `TKA_CTL_RST;
  tka_dev_state_type phase_r;
  tka_dev_state_type phase_nxt;
  logic [5:0]        cnt_r;
  logic [5:0]        cnt_nxt;
  tka_word_type      sh_r;
  tka_word_type      sh_nxt;
  tka_word_type      snap_r;
  tka_word_type      snap_nxt;
  logic              unlock_r;
  logic              unlock_nxt;
  logic              run_r;
  logic              run_nxt;
  logic              sclk_q_r;
  logic              xtal_q_r;
  logic [6:0]        div_r;
  logic [6:0]        div_nxt;
  logic [7:0]        fine_r;
  logic [7:0]        fine_nxt;
  logic [31:0]       coarse_r;
  logic [31:0]       coarse_nxt;
  tka_word_type      bit_in;
  logic [15:0]       ctl_view;
  logic              load_now;
  logic              sclk_rise;
  logic              xtal_rise;
  logic              tick;

  // Edge detection; link and crystal are synchronous to CLK
  assign sclk_rise = link.sclk & ~sclk_q_r;
  assign xtal_rise = XTAL_32K & ~xtal_q_r;
  assign bit_in    = {sh_r[38:0], link.mosi};

  // Control word as seen on a control read
  always_comb
  begin
    ctl_view                  = 16'h0000;
    ctl_view[`TKA_CTL_UNLOCK] = unlock_r;
    ctl_view[`TKA_CTL_RUN]    = run_r;
  end

  // **********************************************************************
  // Serial link decoder
  // **********************************************************************
  // Next state of the link group
  always_comb
  begin
    phase_nxt  = phase_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    snap_nxt   = snap_r;
    unlock_nxt = unlock_r;
    run_nxt    = run_r;
    load_now   = 1'b0;
    if (link.cs_n)
    begin
      // Frame over: a partial time write never loaded, so it is lost
      phase_nxt = TKA_D_CMD;
      cnt_nxt   = 6'h00;
    end
    else if (sclk_rise)
    begin
      cnt_nxt = cnt_r + 6'h01;
      sh_nxt  = bit_in;
      case (phase_r)
        TKA_D_CMD:
        begin
          if (cnt_r == `TKA_CMD_BITS - 6'h01)
          begin
            cnt_nxt = 6'h00;
            if (bit_in[`TKA_CMD_READ])
            begin
              phase_nxt = TKA_D_RD;
              // Frozen copy, so a carry during the shift cannot tear it
              if (bit_in[6:0] == `TKA_ADR_TIME)
                snap_nxt = {coarse_r, fine_r};
              else if (bit_in[6:0] == `TKA_ADR_CTL)
                snap_nxt = {ctl_view, 24'h000000};
              else
                snap_nxt = 40'h00_0000_0000;
            end
            else if (bit_in[6:0] == `TKA_ADR_TIME)
              phase_nxt = TKA_D_WTIME;
            else if (bit_in[6:0] == `TKA_ADR_CTL)
              phase_nxt = TKA_D_WCTL;
            else
              phase_nxt = TKA_D_SKIP;
          end
        end
        TKA_D_WCTL:
        begin
          if (cnt_r == `TKA_CTL_BITS - 6'h01)
          begin
            phase_nxt  = TKA_D_SKIP;
            // Unlock lands only now; run uses the unlock held before
            unlock_nxt = bit_in[`TKA_CTL_UNLOCK];
            if (unlock_r)
              run_nxt = bit_in[`TKA_CTL_RUN];
          end
        end
        TKA_D_WTIME:
        begin
          if (cnt_r == `TKA_TIME_BITS - 6'h01)
          begin
            phase_nxt = TKA_D_SKIP;
            load_now  = unlock_r;
          end
        end
        TKA_D_RD:
        begin
          // Host sampled the current bit at this edge; present next
          snap_nxt = {snap_r[38:0], 1'b0};
        end
        TKA_D_SKIP:
        begin
          cnt_nxt = cnt_r;
        end
        default:
        begin
          phase_nxt = TKA_D_SKIP;
        end
      endcase
    end
  end

  // Link group registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      phase_r  <= TKA_D_CMD;
      cnt_r    <= 6'h00;
      sh_r     <= 40'h00_0000_0000;
      snap_r   <= 40'h00_0000_0000;
      unlock_r <= CTL_RST[`TKA_CTL_UNLOCK];
      run_r    <= CTL_RST[`TKA_CTL_RUN];
      sclk_q_r <= 1'b0;
    end
    else if (CE)
    begin
      phase_r  <= phase_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      snap_r   <= snap_nxt;
      unlock_r <= unlock_nxt;
      run_r    <= run_nxt;
      sclk_q_r <= link.sclk;
    end
  end

  // **********************************************************************
  // Timekeeping counters
  // **********************************************************************
  // Tick divider and counter next values
  always_comb
  begin
    div_nxt    = div_r;
    fine_nxt   = fine_r;
    coarse_nxt = coarse_r;
    tick       = 1'b0;
    if (xtal_rise)
    begin
      if (div_r == `TKA_TICK_LAST)
      begin
        div_nxt = 7'h00;
        tick    = 1'b1;
      end
      else
        div_nxt = div_r + 7'h01;
    end
    // A load wins over the tick that shares its cycle
    if (load_now)
    begin
      coarse_nxt = bit_in[39:8];
      fine_nxt   = bit_in[7:0];
    end
    else if (run_r && tick)
    begin
      fine_nxt = fine_r + 8'h01;
      if (fine_r == `TKA_FINE_MAX)
        coarse_nxt = coarse_r + 32'h0000_0001;
    end
  end

  // Counter group registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      div_r    <= 7'h00;
      fine_r   <= `TKA_FINE_RST;
      coarse_r <= `TKA_COARSE_RST;
      xtal_q_r <= 1'b0;
    end
    else if (CE)
    begin
      div_r    <= div_nxt;
      fine_r   <= fine_nxt;
      coarse_r <= coarse_nxt;
      xtal_q_r <= XTAL_32K;
    end
  end

  // **********************************************************************
  // Outputs, all straight from flops
  // **********************************************************************
  assign link.miso    = snap_r[39];
  assign COARSE_TIME  = coarse_r;
  assign FINE_TIME    = fine_r;
  assign WRITE_UNLOCK = unlock_r;
  assign RUN_ENABLE   = run_r;
endmodule

/* File: logic/tka_host_end.sv */
`timescale 1ns/10ps
`include "tka_map.svh"
module tka_host_end
(
  // Clock, reset, enable
  input  wire logic   CLK,
  input  wire logic   RST,
  input  wire logic   CE,
  // Software register port
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  // Serial link
  tka_link_if.host    link
);
  import tka_pkg::*;

  // **********************************************************************
  // Declarations
  // **********************************************************************
  tka_host_state_type st_r;
  tka_host_state_type st_nxt;
  logic [47:0]        sh_r;
  logic [47:0]        sh_nxt;
  tka_word_type       tx_r;
  tka_word_type       tx_nxt;
  tka_word_type       rx_r;
  tka_word_type       rx_nxt;
  logic [5:0]         left_r;
  logic [5:0]         left_nxt;
  logic [3:0]         div_r;
  logic [3:0]         div_nxt;
  logic               sclk_r;
  logic               sclk_nxt;
  logic               cs_n_r;
  logic               cs_n_nxt;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic               half_done;

  assign half_done = (div_r == `TKA_SCLK_HALF - 4'h1);

  // **********************************************************************
  // Register port and frame sequencer
  // **********************************************************************
  // One command per frame; run only changes on a control write once an earlier write has set unlock
  always_comb
  begin
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    left_nxt  = left_r;
    sclk_nxt  = sclk_r;
    cs_n_nxt  = cs_n_r;
    rdata_nxt = 32'h0000_0000;
    div_nxt   = half_done ? 4'h0 : div_r + 4'h1;
    if (RD)
    begin
      case (ADDR)
        `TKA_H_TXHI: rdata_nxt = {24'h000000, tx_r[39:32]};
        `TKA_H_TXLO: rdata_nxt = tx_r[31:0];
        `TKA_H_STAT: rdata_nxt = {31'h0000_0000, st_r != TKA_H_IDLE};
        `TKA_H_RXHI: rdata_nxt = {24'h000000, rx_r[39:32]};
        `TKA_H_RXLO: rdata_nxt = rx_r[31:0];
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (WR && ADDR == `TKA_H_TXHI)
      tx_nxt[39:32] = WDATA[7:0];
    if (WR && ADDR == `TKA_H_TXLO)
      tx_nxt[31:0] = WDATA;
    case (st_r)
      TKA_H_IDLE:
      begin
        div_nxt = 4'h0;
        if (WR && ADDR == `TKA_H_CMD)
        begin
          // Data go out MSB first, coarse bit 31 leading
          sh_nxt   = {WDATA[7:0], tx_r};
          // A short count ends the frame early, as an abort
          left_nxt = `TKA_CMD_BITS +
                     WDATA[`TKA_H_LEN_MSB:`TKA_H_LEN_LSB];
          cs_n_nxt = 1'b0;
          st_nxt   = TKA_H_LOW;
        end
      end
      TKA_H_LOW:
      begin
        if (half_done)
        begin
          sclk_nxt = 1'b1;
          // Device bit sampled as the clock rises; last bits stay low
          rx_nxt   = {rx_r[38:0], link.miso};
          st_nxt   = TKA_H_HIGH;
        end
      end
      TKA_H_HIGH:
      begin
        if (half_done)
        begin
          sclk_nxt = 1'b0;
          sh_nxt   = {sh_r[46:0], 1'b0};
          left_nxt = left_r - 6'h01;
          st_nxt   = (left_r == 6'h01) ? TKA_H_TAIL : TKA_H_LOW;
        end
      end
      TKA_H_TAIL:
      begin
        if (half_done)
        begin
          cs_n_nxt = 1'b1;
          st_nxt   = TKA_H_IDLE;
        end
      end
      default:
      begin
        st_nxt = TKA_H_IDLE;
      end
    endcase
  end

  // Sequencer registers; the clock rate keeps a full read far under 1ms
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_r    <= TKA_H_IDLE;
      sh_r    <= 48'h0000_0000_0000;
      tx_r    <= 40'h00_0000_0000;
      rx_r    <= 40'h00_0000_0000;
      left_r  <= 6'h00;
      div_r   <= 4'h0;
      sclk_r  <= 1'b0;
      cs_n_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else if (CE)
    begin
      st_r    <= st_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      left_r  <= left_nxt;
      div_r   <= div_nxt;
      sclk_r  <= sclk_nxt;
      cs_n_r  <= cs_n_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flops
  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = sh_r[47];
  assign RDATA     = rdata_r;
endmodule

/* File: tb/tka_link_asserts.sv */
`timescale 1ns/10ps
// **********************************************************************
// Serial link timing and framing checks
// **********************************************************************
module tka_link_asserts
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Link lines
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  localparam int RISE_MAX = 48;
  localparam int LOW_MAX  = 25000;
  logic        sclk_r;
  logic        sclk_nxt;
  logic [5:0]  rise_r;
  logic [5:0]  rise_nxt;
  logic [15:0] low_r;
  logic [15:0] low_nxt;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Rises and cycles of the open frame; the cycle count saturates so a hang cannot wrap it
  always_comb
  begin
    sclk_nxt = sclk;
    rise_nxt = cs_n ? 6'h00 : rise_r + 6'(sclk & ~sclk_r);
    low_nxt  = cs_n ? 16'h0000 : low_r + 16'(low_r != 16'hffff);
  end

  // Registers only
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      sclk_r <= 1'b0;
      rise_r <= 6'h00;
      low_r  <= 16'h0000;
    end
    else
    begin
      sclk_r <= sclk_nxt;
      rise_r <= rise_nxt;
      low_r  <= low_nxt;
    end

  property p_idle_low; cs_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("serial clock moved outside a frame");
  property p_high; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
  a_high: assert property (p_high)
    else $error("serial clock high phase not four cycles");
  property p_low; $fell(sclk) && !cs_n |-> !sclk[*4]; endproperty
  a_low: assert property (p_low)
    else $error("serial clock low phase too short");
  property p_start; $fell(cs_n) |-> !sclk[*3] ##[1:6] sclk; endproperty
  a_start: assert property (p_start)
    else $error("frame start without serial clock");
  property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi)
    else $error("host data moved while clock high");
  property p_miso;
    !cs_n && !$past(cs_n) && !sclk && !$past(sclk) |-> $stable(miso);
  endproperty
  a_miso: assert property (p_miso)
    else $error("device data moved while clock low");
  property p_end; $rose(cs_n) |-> !sclk && !$past(sclk, 3); endproperty
  a_end: assert property (p_end)
    else $error("frame closed too soon after last clock");
  property p_len;
    $rose(cs_n) |-> rise_r >= 6'd8 && rise_r <= 6'(RISE_MAX);
  endproperty
  a_len: assert property (p_len)
    else $error("frame clock count out of range");
  property p_time; !cs_n |-> low_r < 16'(LOW_MAX); endproperty
  a_time: assert property (p_time)
    else $error("frame longer than one millisecond");

  // Full word, control word and shortened frames
  c_word: cover property ($rose(cs_n) && rise_r == 6'd48);
  c_ctl: cover property ($rose(cs_n) && rise_r == 6'd24);
  c_short: cover property ($rose(cs_n) && rise_r == 6'd20);
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`include "tka_map.svh"
// **********************************************************************
// Host end driving device end over the link
// **********************************************************************
`define CHK(got, exp) \
  begin \
    #1; \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("Error t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module testbench;
  import tka_pkg::*;
  localparam logic [7:0] TIME_W = {1'b0, `TKA_ADR_TIME};
  localparam logic [7:0] TIME_R = {1'b1, `TKA_ADR_TIME};
  localparam logic [7:0] CTL_W  = {1'b0, `TKA_ADR_CTL};
  localparam tka_word_type W1 = 40'h89_abcd_effe;
  localparam tka_word_type W2 = 40'h89_abcd_f000;
  logic         clk;
  logic         rst;
  logic         ce;
  logic         xtal;
  logic [3:0]   addr;
  logic [31:0]  wdata;
  logic         wr_s;
  logic         rd_s;
  logic [31:0]  rdata;
  logic [31:0]  coarse;
  logic [7:0]   fine;
  logic         unlock;
  logic         run;
  logic [31:0]  r;
  tka_word_type w;
  int           errors;
  int           n_compared;

  tka_link_if link ();
  tka_device_end tka_device_end_i (.CLK(clk), .RST(rst), .CE(ce),
    .XTAL_32K(xtal), .link(link), .COARSE_TIME(coarse),
    .FINE_TIME(fine), .WRITE_UNLOCK(unlock), .RUN_ENABLE(run));
  tka_host_end tka_host_end_i (.CLK(clk), .RST(rst), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .link(link));
  tka_link_asserts tka_link_asserts_i (.CLK(clk), .RST(rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso));

  // Write strobe dropped a cycle before any later access
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  // Word is sent left-aligned from bit 39
  task automatic start(input logic [7:0] c, input logic [5:0] n,
                       input tka_word_type v);
    wr(`TKA_H_TXHI, {24'h0, v[39:32]});
    wr(`TKA_H_TXLO, v[31:0]);
    wr(`TKA_H_CMD, {18'h0, n, c});
  endtask

  // Bounded poll so a stuck frame shows up as a mismatch
  task automatic wait_idle;
    int i;
    r = 32'h1;
    for (i = 0; i < 400 && r[0] !== 1'b0; i++)
      rd(`TKA_H_STAT, r);
    `CHK(r[0], 1'b0)
  endtask

  task automatic xfer(input logic [7:0] c, input logic [5:0] n,
                      input tka_word_type v);
    start(c, n, v);
    wait_idle();
  endtask

  task automatic get_rx(output tka_word_type v);
    logic [31:0] h;
    rd(`TKA_H_RXHI, h);
    rd(`TKA_H_RXLO, r);
    v = {h[7:0], r};
  endtask

  // Crystal sped up to keep the run short; the 128:1 ratio is unchanged
  task automatic ticks(input int n);
    repeat (n)
    begin
      xtal <= 1'b1;
      repeat (2) @(posedge clk);
      xtal <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic finish_test;
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // System clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog, well past the expected length of the run
  initial
  begin
    repeat (30000) @(posedge clk);
    `CHK(1'b0, 1'b1)
    finish_test();
  end

  // Scenarios in order; later ones rely on the divider phase so far
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    xtal = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({coarse, fine}, 40'h0)
    `CHK({unlock, run}, 2'b01)
    xfer(TIME_W, `TKA_TIME_BITS, W1);
    `CHK({coarse, fine}, 40'h0)
    start(CTL_W, `TKA_CTL_BITS, {16'h1000, 24'h0});
    repeat (180) @(posedge clk);
    `CHK(unlock, 1'b0)
    wait_idle();
    `CHK({unlock, run}, 2'b11)
    xfer(CTL_W, `TKA_CTL_BITS, {16'h1000, 24'h0});
    `CHK(run, 1'b0)
    xfer(TIME_W, 6'd39, W1);
    `CHK({coarse, fine}, 40'h0)
    xfer(TIME_W, `TKA_TIME_BITS, W1);
    `CHK({coarse, fine}, W1)
    xfer(TIME_R, `TKA_TIME_BITS, 40'h0);
    get_rx(w);
    `CHK(w, W1)
    xfer(CTL_W, `TKA_CTL_BITS, {16'h1800, 24'h0});
    `CHK(run, 1'b1)
    ticks(127);
    `CHK(fine, 8'hfe)
    ticks(1);
    `CHK(fine, 8'hff)
    ticks(128);
    `CHK({coarse, fine}, W2)
    ticks(100);
    start(TIME_R, `TKA_TIME_BITS, 40'h0);
    ticks(28);
    wait_idle();
    get_rx(w);
    `CHK(w, W2)
    `CHK(fine, 8'h01)
    // Clock enable low: crystal edges ignored, nothing moves
    ce <= 1'b0;
    ticks(130);
    ce <= 1'b1;
    `CHK({coarse, fine}, W2 + 40'h1)
    xfer(CTL_W, `TKA_CTL_BITS, {16'h1000, 24'h0});
    ticks(130);
    `CHK({coarse, fine}, W2 + 40'h1)
    xfer(TIME_R, 6'd12, 40'h0);
    rd(`TKA_H_RXLO, r);
    `CHK(r[11:0], 12'h89a)
    wr(`TKA_H_TXHI, 32'h0000_00a5);
    rd(`TKA_H_TXHI, r);
    `CHK(r[7:0], 8'ha5)
    rd(4'hf, r);
    `CHK(r, 32'h0)
    finish_test();
  end
endmodule
